// *** hdl/edge_latch.sv ***
// Synchronises pins and latches a falling edge per line until cleared
module edge_latch #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys, // System clock
	input wire logic srst, // Sync reset
	input wire logic [WIDTH-1:0] pinIn, // Asynchronous pins
	input wire logic clearPend, // Clear all latched edges
	output logic [WIDTH-1:0] pending // Latched requests
);
	// Elaboration check: a latch without lines has nothing to watch
	if (WIDTH < 1) begin : g_bad_width
		$error("edge_latch WIDTH must be positive");
	end

	logic [WIDTH-1:0] sync1_r;
	logic [WIDTH-1:0] sync2_r;
	logic [WIDTH-1:0] prev_r;
	logic [WIDTH-1:0] pend_r;

	// Two-flop synchroniser, then edge history off the second stage only
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sync1_r <= '1;
			sync2_r <= '1;
			prev_r <= '1;
		end else begin
			sync1_r <= pinIn;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_line
			wire fallEdge = prev_r[i] & ~sync2_r[i];
			// Edge beats a simultaneous clear so no request is lost
			always_ff @(posedge clk_sys) begin
				if (srst)
					pend_r[i] <= 1'b0;
				else if (fallEdge)
					pend_r[i] <= 1'b1;
				else if (clearPend)
					pend_r[i] <= 1'b0;
			end
		end
	endgenerate

	assign pending = pend_r;
endmodule // edge_latch

// *** hdl/interrupt_status_flags.sv ***
module interrupt_status_flags (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic srst, // Synchronous reset, active high
	input wire logic [3:0] regAddr, // Register index
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	output logic [7:0] regRdata, // Read data, cycle after strobe
	input wire logic extPin_n, // External request pin, active low
	input wire logic [7:0] keypadLines, // Keypad pins
	input wire logic lockIn, // Clock generator lock indicator
	input wire logic convDone, // Conversion complete pulse
	input wire logic [2:0] timerOneReq, // Timer one ch0, ch1, overflow
	input wire logic [2:0] timerTwoReq, // Timer two ch0, ch1, overflow
	input wire logic [1:0] spiReq, // Serial peripheral rx, tx
	input wire logic [2:0] asyncReq, // Async serial error, rx, tx
	output logic [15:0] cpuReq, // Request lines to CPU, flag order
	output logic irqOut // Summary interrupt output
);
	// ----------------------------------------------------------------
	// Elaboration checks on the package layout
	// ----------------------------------------------------------------
	// The read words place the tick flag at bit 3 and the lock flag at bit 1
	if (irq_status_pkg::TICK_FLAG_BIT != 3 || irq_status_pkg::LOCK_FLAG_BIT != 1) begin : g_bad_pos
		$error("flag positions differ from the read word layout");
	end
	// The acknowledge strobe must sit inside the byte-wide write data
	if (irq_status_pkg::TICK_ACK_BIT > 7) begin : g_bad_ack
		$error("tick acknowledge bit outside the byte");
	end
	// The status and mask words are built from exactly five events
	if (irq_status_pkg::EVT_W != 5) begin : g_bad_evt
		$error("event word must hold five events");
	end
	// The keypad port is one byte wide, so the latch must match it
	if (irq_status_pkg::KEY_LINES != 8) begin : g_bad_keys
		$error("keypad latch width differs from the keypad port");
	end
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [1:0] pinSync_r;
	logic [1:0] lockSync_r;
	logic pinPrev_r;
	logic lockPrev_r;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pinSync_r <= 2'h3;
			lockSync_r <= 2'h0;
			pinPrev_r <= 1'b1;
			lockPrev_r <= 1'b0;
		end else begin
			pinSync_r <= {pinSync_r[0], extPin_n};
			lockSync_r <= {lockSync_r[0], lockIn};
			pinPrev_r <= pinSync_r[1];
			lockPrev_r <= lockSync_r[1];
		end
	end

	wire pinFall = pinPrev_r & ~pinSync_r[1];
	wire lockChange = lockPrev_r ^ lockSync_r[1];

	// ----------------------------------------------------------------
	// Register decode
	// ----------------------------------------------------------------
	// Index map of the byte-wide register port:
	//   0..2 pending words, read only, writes ignored
	//   3 control: enables for conversion, tick, lock, keypad, pin
	//   4 tick: rate select, live tick flag, acknowledge strobe
	//   5 event status, write one to clear
	//   6 event mask, same layout as the status word
	//   7 conversion word: done flag, lock-change flag
	// Reads of unmapped indices return zero and never stall the port
	logic [7:0] ctrl_r;
	logic [2:0] tickRate_r;
	logic [4:0] evtStat_r;
	logic [4:0] evtMask_r;
	logic tickFlag_r;
	logic lockFlag_r;
	logic pinPend_r;
	logic convPend_r;
	logic convDoneFlag_r;

	wire wrCtrl = regWr && (regAddr == irq_status_pkg::ADDR_CTRL);
	wire wrTick = regWr && (regAddr == irq_status_pkg::ADDR_TICK);
	wire wrStat = regWr && (regAddr == irq_status_pkg::ADDR_EVT_STAT);
	wire wrMask = regWr && (regAddr == irq_status_pkg::ADDR_EVT_MASK);
	wire wrConv = regWr && (regAddr == irq_status_pkg::ADDR_CONV);
	wire rdConv = regRd && (regAddr == irq_status_pkg::ADDR_CONV);
	wire convIen = ctrl_r[irq_status_pkg::CTRL_CONV_IEN];
	wire tickIen = ctrl_r[irq_status_pkg::CTRL_TICK_IEN];
	wire lockIen = ctrl_r[irq_status_pkg::CTRL_LOCK_IEN];
	wire keyIen = ctrl_r[irq_status_pkg::CTRL_KEY_IEN];
	wire pinIen = ctrl_r[irq_status_pkg::CTRL_PIN_IEN];
	wire tickAck = wrTick && regWdata[irq_status_pkg::TICK_ACK_BIT];
	// Writing one to the lock flag bit of the conversion word clears it
	wire lockClr = wrConv && regWdata[irq_status_pkg::LOCK_FLAG_BIT];

	// Control word: interrupt enables of the five local sources
	always_ff @(posedge clk_sys) begin
		if (srst)
			ctrl_r <= irq_status_pkg::CTRL_RST;
		else if (wrCtrl)
			ctrl_r <= regWdata;
	end

	// Rate select; an acknowledge write must repeat the wanted rate
	always_ff @(posedge clk_sys) begin
		if (srst)
			tickRate_r <= irq_status_pkg::TICK_RATE_RST;
		else if (wrTick)
			tickRate_r <= regWdata[2:0];
	end

	// Event mask, same layout as the event status word
	always_ff @(posedge clk_sys) begin
		if (srst)
			evtMask_r <= irq_status_pkg::EVT_MASK_RST;
		else if (wrMask)
			evtMask_r <= regWdata[4:0];
	end

	// ----------------------------------------------------------------
	// Keypad and tick sub-blocks
	// ----------------------------------------------------------------
	logic [irq_status_pkg::KEY_LINES-1:0] keyPend;
	logic tickRoll;
	// Keypad latch clears on a control write with its enable bit zero, like an acknowledge
	wire keyClr = wrCtrl && !regWdata[irq_status_pkg::CTRL_KEY_IEN];

	edge_latch #(
		.WIDTH(irq_status_pkg::KEY_LINES)
	) u_keys (
		.clk_sys(clk_sys),
		.srst(srst),
		.pinIn(keypadLines),
		.clearPend(keyClr),
		.pending(keyPend)
	);

	tick_divider #(
		.BASE(irq_status_pkg::TICK_BASE_CYCLES)
	) u_tick (
		.clk_sys(clk_sys),
		.srst(srst),
		.rateSel(tickRate_r),
		.rollPulse(tickRoll)
	);

	// Keypad event fires once per newly latched line, not while it stays
	// pending, so clearing its status bit is not undone in the next cycle
	logic [irq_status_pkg::KEY_LINES-1:0] keyPendPrev_r;
	wire keyNew = |(keyPend & ~keyPendPrev_r);

	always_ff @(posedge clk_sys) begin
		if (srst)
			keyPendPrev_r <= '0;
		else
			keyPendPrev_r <= keyPend;
	end

	// ----------------------------------------------------------------
	// Source flags: set beats clear in the same cycle
	// ----------------------------------------------------------------
	// Tick flag on rollover
	always_ff @(posedge clk_sys) begin
		if (srst)
			tickFlag_r <= 1'b0;
		else if (tickRoll)
			tickFlag_r <= 1'b1;
		else if (tickAck)
			tickFlag_r <= 1'b0;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			lockFlag_r <= 1'b0;
		else if (lockChange)
			lockFlag_r <= 1'b1;
		else if (lockClr)
			lockFlag_r <= 1'b0;
	end

	// External pin falling edge latched; a control write with its enable clear drops it
	always_ff @(posedge clk_sys) begin
		if (srst)
			pinPend_r <= 1'b0;
		else if (pinFall)
			pinPend_r <= 1'b1;
		else if (wrCtrl && !regWdata[irq_status_pkg::CTRL_PIN_IEN])
			pinPend_r <= 1'b0;
	end

	// Completion raises a request while enabled; a read of the word retires it
	always_ff @(posedge clk_sys) begin
		if (srst)
			convPend_r <= 1'b0;
		else if (convDone && convIen)
			convPend_r <= 1'b1;
		else if (rdConv || !convIen)
			convPend_r <= 1'b0;
	end

	// Done flag only used when interrupts are off
	always_ff @(posedge clk_sys) begin
		if (srst)
			convDoneFlag_r <= 1'b0;
		else if (convDone && !convIen)
			convDoneFlag_r <= 1'b1;
		else if (rdConv || convIen)
			convDoneFlag_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Request lines in flag order
	// ----------------------------------------------------------------
	wire keyReq = (|keyPend) & keyIen;
	wire tickReq = tickFlag_r & tickIen;
	// Lock request gated by its enable
	wire lockReq = lockFlag_r & lockIen;
	wire pinReq = pinPend_r & pinIen;

	// Only maskable sources; fixed order, bit 0 is flag 1
	wire [15:0] pendAll = {
		tickReq,
		convPend_r,
		keyReq,
		asyncReq[2], // Flag 13, transmit
		asyncReq[1], // Flag 12, receive
		asyncReq[0], // Flag 11, error
		spiReq[1],
		spiReq[0],
		timerTwoReq[2],
		timerTwoReq[1],
		timerTwoReq[0],
		timerOneReq[2],
		timerOneReq[1],
		timerOneReq[0],
		lockReq,
		pinReq
	};

	assign cpuReq = pendAll;

	// ----------------------------------------------------------------
	// Event status, mask and summary interrupt
	// ----------------------------------------------------------------
	wire [4:0] evtSet = {
		tickRoll,
		convDone,
		lockChange,
		pinFall,
		keyNew
	};
	// Write-one-to-clear per event bit; a set in the same cycle wins, so an
	// event that lands beside the clearing write is never lost
	genvar e;
	generate
		for (e = 0; e < irq_status_pkg::EVT_W; e = e + 1) begin : g_evt
			wire evtClr = wrStat && regWdata[e];
			always_ff @(posedge clk_sys) begin
				if (srst)
					evtStat_r[e] <= 1'b0;
				else if (evtSet[e])
					evtStat_r[e] <= 1'b1;
				else if (evtClr)
					evtStat_r[e] <= 1'b0;
			end
		end
	endgenerate

	assign irqOut = |(evtStat_r & evtMask_r);

	// ----------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------
	// Live flags; low register bits 1..0 zero
	wire [7:0] rdLow = {pendAll[5:0], 2'b00};
	wire [7:0] rdMid = pendAll[13:6];
	// High register flags 16,15 low, rest zero
	wire [7:0] rdHigh = {6'h00, pendAll[15:14]};
	wire [7:0] rdTick = {4'h0, tickFlag_r, tickRate_r};
	wire [7:0] rdConvW = {6'h00, lockFlag_r, convDoneFlag_r};

	// Pending status words have no write decode at all; event status clears on write-one
	logic [7:0] rdMux;
	always_comb begin
		case (regAddr)
			irq_status_pkg::ADDR_PEND_LOW: rdMux = rdLow;
			irq_status_pkg::ADDR_PEND_MID: rdMux = rdMid;
			irq_status_pkg::ADDR_PEND_HIGH: rdMux = rdHigh;
			irq_status_pkg::ADDR_CTRL: rdMux = ctrl_r;
			irq_status_pkg::ADDR_TICK: rdMux = rdTick;
			irq_status_pkg::ADDR_EVT_STAT: rdMux = {3'h0, evtStat_r};
			irq_status_pkg::ADDR_EVT_MASK: rdMux = {3'h0, evtMask_r};
			irq_status_pkg::ADDR_CONV: rdMux = rdConvW;
			default: rdMux = 8'h00;
		endcase
	end

	// Read data registered; holds zero outside the answer cycle
	always_ff @(posedge clk_sys) begin
		if (srst)
			regRdata <= 8'h00;
		else if (regRd)
			regRdata <= rdMux;
		else
			regRdata <= 8'h00;
	end
endmodule // interrupt_status_flags

// *** hdl/irq_status_pkg.sv ***
package irq_status_pkg;
	// ----------------------------------------------------------------
	// Register map (word-free byte bus, indices chosen locally)
	// ----------------------------------------------------------------
	localparam logic [3:0] ADDR_PEND_LOW = 4'h0;
	localparam logic [3:0] ADDR_PEND_MID = 4'h1;
	localparam logic [3:0] ADDR_PEND_HIGH = 4'h2;
	localparam logic [3:0] ADDR_CTRL = 4'h3;
	localparam logic [3:0] ADDR_TICK = 4'h4;
	localparam logic [3:0] ADDR_EVT_STAT = 4'h5;
	localparam logic [3:0] ADDR_EVT_MASK = 4'h6;
	localparam logic [3:0] ADDR_CONV = 4'h7;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int CTRL_CONV_IEN = 0;
	localparam int CTRL_TICK_IEN = 1;
	localparam int CTRL_LOCK_IEN = 2;
	localparam int CTRL_KEY_IEN = 3;
	localparam int CTRL_PIN_IEN = 4;
	localparam int TICK_ACK_BIT = 7;
	localparam int TICK_FLAG_BIT = 3;
	localparam int EVT_KEY = 0;
	localparam int EVT_PIN = 1;
	localparam int EVT_LOCK = 2;
	localparam int EVT_CONV = 3;
	localparam int EVT_TICK = 4;
	localparam int EVT_W = 5;
	localparam int LOCK_FLAG_BIT = 1;
	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [2:0] TICK_RATE_RST = 3'h0;
	localparam logic [4:0] EVT_MASK_RST = 5'h00;
	// Shortest tick period in cycles; each rate step doubles it
	localparam int TICK_BASE_CYCLES = 8;
	localparam int KEY_LINES = 8;
endpackage

// *** hdl/tick_divider.sv ***
// Counter chain with selectable rollover; one-cycle pulse on rollover
module tick_divider #(
	parameter int BASE = irq_status_pkg::TICK_BASE_CYCLES
) (
	input wire logic clk_sys, // System clock
	input wire logic srst, // Sync reset
	input wire logic [2:0] rateSel, // Rollover rate select
	output logic rollPulse // One-cycle rollover pulse
);
	localparam int CW = $clog2(BASE) + 8;
	// Elaboration check: a base below two leaves no room for a rollover pulse
	if (BASE < 2) begin : g_bad_base
		$error("tick_divider BASE must be at least 2");
	end

	logic [CW-1:0] count_r;
	wire [CW-1:0] limit = CW'((BASE << rateSel) - 1);
	wire atLimit = (count_r >= limit);

	// Free-running chain; a rate change simply re-targets the limit
	always_ff @(posedge clk_sys) begin
		if (srst)
			count_r <= '0;
		else if (atLimit)
			count_r <= '0;
		else
			count_r <= count_r + 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (srst)
			rollPulse <= 1'b0;
		else
			rollPulse <= atLimit;
	end
endmodule // tick_divider

// *** tb/interrupt_status_flags_properties.sv ***
// Sees only the top ports; status register contents are tied to live request lines
module interrupt_status_flags_chk (
	input wire logic clk_sys, // System clock
	input wire logic srst, // Sync reset
	input wire logic [3:0] regAddr, // Register index
	input wire logic [7:0] regWdata, // Write data
	input wire logic regWr, // Write strobe
	input wire logic regRd, // Read strobe
	input wire logic [7:0] regRdata, // Read data
	input wire logic extPin_n, // External pin
	input wire logic [7:0] keypadLines, // Keypad pins
	input wire logic lockIn, // Lock indicator
	input wire logic convDone, // Conversion pulse
	input wire logic [2:0] timerOneReq, // Timer one requests
	input wire logic [2:0] timerTwoReq, // Timer two requests
	input wire logic [1:0] spiReq, // Serial peripheral requests
	input wire logic [2:0] asyncReq, // Async serial requests
	input wire logic [15:0] cpuReq, // Requests to CPU
	input wire logic irqOut // Summary interrupt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	map_low_a: assert property (regRd && regAddr == irq_status_pkg::ADDR_PEND_LOW
		|=> regRdata == {$past(cpuReq[5:0]), 2'b00}) else $error("low status read mismatch");
	map_mid_a: assert property (regRd && regAddr == irq_status_pkg::ADDR_PEND_MID
		|=> regRdata == $past(cpuReq[13:6])) else $error("mid status read mismatch");
	map_high_a: assert property (regRd && regAddr == irq_status_pkg::ADDR_PEND_HIGH
		|=> regRdata == {6'h00, $past(cpuReq[15:14])}) else $error("high status read mismatch");
	// read data only after a strobe
	idle_zero_a: assert property (!regRd |=> regRdata == 8'h00)
		else $error("read data outside read slot");
	timer_live_a: assert property (cpuReq[7:2] == {timerTwoReq, timerOneReq})
		else $error("timer flags off");
	serial_live_a: assert property (cpuReq[12:8] == {asyncReq, spiReq})
		else $error("serial flags off");
	conv_cause_a: assert property ($rose(cpuReq[14]) |-> $past(convDone))
		else $error("conversion request without completion");
	reset_quiet_a: assert property ($fell(srst) |-> !irqOut && cpuReq[15:13] == 3'h0
		&& cpuReq[1:0] == 2'h0) else $error("request left after reset");
	cover property (regRd ##1 regRdata != 8'h00);
	cover property ($rose(irqOut));
	cover property ($rose(cpuReq[15]));
endmodule // interrupt_status_flags_chk

bind interrupt_status_flags interrupt_status_flags_chk interrupt_status_flags_chk_i (
	.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
	.regRd(regRd), .regRdata(regRdata), .extPin_n(extPin_n), .keypadLines(keypadLines),
	.lockIn(lockIn), .convDone(convDone), .timerOneReq(timerOneReq),
	.timerTwoReq(timerTwoReq), .spiReq(spiReq), .asyncReq(asyncReq), .cpuReq(cpuReq),
	.irqOut(irqOut));

// *** tb/interrupt_status_flags_tb_top.sv ***
module interrupt_status_flags_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, extPin_n = 1'b1;
	logic lockIn = 1'b0, fireConv = 1'b0, convDone, irqOut;
	logic [3:0] regAddr = 4'h0;
	logic [7:0] regWdata = 8'h00, keypadLines = 8'hff, regRdata, d;
	logic [2:0] t1, t2, as;
	logic [1:0] sp;
	logic [10:0] reqSet = 11'h000;
	logic [15:0] cpuReq;
	int n_fail = 0, checked = 0, t0;
	always #5 clk_sys = ~clk_sys;
	periph_src_model periph_src_model_i (.clk_sys(clk_sys), .reqSet(reqSet),
		.fireConv(fireConv), .timerOneReq(t1), .timerTwoReq(t2), .spiReq(sp),
		.asyncReq(as), .convDone(convDone));
	interrupt_status_flags interrupt_status_flags_i (.clk_sys(clk_sys), .srst(srst),
		.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
		.regRdata(regRdata), .extPin_n(extPin_n), .keypadLines(keypadLines), .lockIn(lockIn),
		.convDone(convDone), .timerOneReq(t1), .timerTwoReq(t2), .spiReq(sp),
		.asyncReq(as), .cpuReq(cpuReq), .irqOut(irqOut));
	task chk(input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			n_fail++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task tally_and_finish;
		if (n_fail == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		regWr <= 1'b1; regAddr <= a; regWdata <= v;
		@(posedge clk_sys);
		regWr <= 1'b0;
		#1;
	endtask
	// Data stand only in the cycle after the strobe, so sample there
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		regRd <= 1'b1; regAddr <= a;
		@(posedge clk_sys);
		regRd <= 1'b0;
		#1 d = regRdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	// Bounded wait; the slowest tick rate needs about 1024 cycles
	task waitHi(input int b);
		for (int i = 0; i < 2100 && cpuReq[b] !== 1'b1; i++) cyc(1);
		chk(8'(cpuReq[b]), 8'h01);
	endtask
	task t_map;
		reqSet <= 11'b110_10_011_101;
		cyc(3);
		rd(irq_status_pkg::ADDR_PEND_LOW); chk(d, {t2[0], t1, 4'h0});
		rd(irq_status_pkg::ADDR_PEND_MID); chk(d, {1'b0, as, sp, t2[2:1]});
		for (int a = 0; a < 3; a++) wr(4'(a), 8'hff);
		rd(irq_status_pkg::ADDR_PEND_MID); chk(d, 8'h69);
		rd(irq_status_pkg::ADDR_PEND_HIGH); chk(d, 8'h00);
		rd(4'hf); chk(d, 8'h00);
		rd(irq_status_pkg::ADDR_EVT_MASK); chk(d, 8'h00);
		reqSet <= 11'h000;
	endtask
	task t_key;
		wr(irq_status_pkg::ADDR_CTRL, 8'h08);
		wr(irq_status_pkg::ADDR_EVT_MASK, 8'h01);
		keypadLines <= 8'hdf;
		cyc(6);
		chk(8'(cpuReq[13]), 8'h01);
		chk(8'(irqOut), 8'h01);
		wr(irq_status_pkg::ADDR_EVT_MASK, 8'h00); chk(8'(irqOut), 8'h00);
		wr(irq_status_pkg::ADDR_EVT_MASK, 8'h01); chk(8'(irqOut), 8'h01);
		wr(irq_status_pkg::ADDR_EVT_STAT, 8'h01); chk(8'(irqOut), 8'h00);
		keypadLines <= 8'hff;
		wr(irq_status_pkg::ADDR_CTRL, 8'h00); chk(8'(cpuReq[13]), 8'h00);
	endtask
	task t_conv(input logic en);
		wr(irq_status_pkg::ADDR_CTRL, {7'h00, en});
		fireConv <= 1'b1;
		cyc(1);
		fireConv <= 1'b0;
		cyc(3);
		chk(8'(cpuReq[14]), 8'(en));
		rd(irq_status_pkg::ADDR_CONV); chk(8'(d[0]), 8'(!en));
		chk(8'(cpuReq[14]), 8'h00);
	endtask
	// Rise-to-rise spacing of the tick flag gives the rollover period
	task t_tick;
		wr(irq_status_pkg::ADDR_CTRL, 8'h02);
		for (int r = 0; r < 8; r++) begin
			wr(irq_status_pkg::ADDR_TICK, 8'h80 | 8'(r));
			waitHi(15);
			t0 = int'($time);
			wr(irq_status_pkg::ADDR_TICK, 8'h80 | 8'(r)); chk(8'(cpuReq[15]), 8'h00);
			waitHi(15);
			chk(16'(($time - t0) / 10), 16'(irq_status_pkg::TICK_BASE_CYCLES << r));
			if (r == 0) begin
				rd(irq_status_pkg::ADDR_TICK); chk(8'(d[3]), 8'h01);
			end
		end
		wr(irq_status_pkg::ADDR_CTRL, 8'h00);
		cyc(40);
		chk(8'(cpuReq[15]), 8'h00);
	endtask
	task t_pin_lock;
		wr(irq_status_pkg::ADDR_CTRL, 8'h14);
		extPin_n <= 1'b0; lockIn <= 1'b1;
		cyc(6);
		rd(irq_status_pkg::ADDR_PEND_LOW); chk(d, 8'h0c);
		extPin_n <= 1'b1;
		wr(irq_status_pkg::ADDR_CONV, 8'h02); chk(8'(cpuReq[1]), 8'h00);
		// Lock enable off: the flag still sets, but no request reaches the CPU
		wr(irq_status_pkg::ADDR_CTRL, 8'h10);
		lockIn <= 1'b0;
		cyc(6);
		chk(8'(cpuReq[1]), 8'h00);
		rd(irq_status_pkg::ADDR_CONV);
		chk(8'(d[1]), 8'h01);
		wr(irq_status_pkg::ADDR_CONV, 8'h02);
		wr(irq_status_pkg::ADDR_CTRL, 8'h00);
	endtask
	// Cut off a hang well past the expected run length
	initial begin
		#300000;
		n_fail++;
		tally_and_finish;
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		cyc(1);
		chk(8'(irqOut), 8'h00);
		t_map;
		t_key;
		t_conv(1'b1);
		t_conv(1'b0);
		t_pin_lock;
		t_tick;
		tally_and_finish;
	end
endmodule // interrupt_status_flags_tb_top

// *** tb/periph_src_model.sv ***
// On-chip sources: level requests and a one-cycle completion pulse, all clock-aligned
module periph_src_model (
	input wire logic clk_sys, // System clock
	input wire logic [10:0] reqSet, // Wanted levels {async, spi, t2, t1}
	input wire logic fireConv, // Completion command
	output logic [2:0] timerOneReq, // Timer one levels
	output logic [2:0] timerTwoReq, // Timer two levels
	output logic [1:0] spiReq, // Serial peripheral levels
	output logic [2:0] asyncReq, // Async serial levels
	output logic convDone = 1'b0 // Completion pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {asyncReq, spiReq, timerTwoReq, timerOneReq} = 11'h000;
	// Registered so sources change only after an edge, as real flags do
	always @(posedge clk_sys) begin
		{asyncReq, spiReq, timerTwoReq, timerOneReq} <= reqSet;
		convDone <= fireConv;
	end
endmodule // periph_src_model
